// >>> rtl/iod_output_regs.sv
`timescale 1ns/100ps
// Contract
// - Y angle increment, 16-bit signed, 0x26
// - Z angle increment, 16-bit signed, 0x28
// - Count weighs rate scale times (decimation+1)/fs
// - Select 00 uses 2048 Hz, else external
// - Primary acceleration 16-bit signed, 0.25 mg
// - Extension holds filter growth low bits
// - Acceleration registers read-only at 0x10..0x1A
// - Each axis own pair, all refreshed
// - Y primary acceleration at 0x16
// - Z pair at 0x1A and 0x18
// - Increment covers one processing cycle
// - Rate scale is 0.005 deg/s per count
module iod_output_regs
  import iod_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES,
  parameter int DEC_BITS = DEC_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic [DEC_BITS-1:0] decimation_setting,
  input wire logic [DATA_W-1:0] misc_control_word,
  input wire logic ext_sample_pulse,
  // Sensor data
  input wire logic [DATA_W-1:0] gyro_y_rate,
  input wire logic [DATA_W-1:0] gyro_z_rate,
  input wire logic [WIDE_W-1:0] accel_x_data,
  input wire logic [WIDE_W-1:0] accel_y_data,
  input wire logic [WIDE_W-1:0] accel_z_data,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Status
  output logic data_ready
);

  localparam int ACC_W = DATA_W + DEC_BITS;
  localparam int DIV_W = DEC_BITS + 1;
  localparam int AXES = 2;

  // ----------------------------------------------------------------
  // Sample pacing
  // ----------------------------------------------------------------
  logic int_tick;
  logic sample_tick;
  logic use_internal;

  iod_tick_gen #(
    .PERIOD(SAMPLE_PERIOD)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(int_tick)
  );

  assign use_internal =
    misc_control_word[CLKSEL_MSB:CLKSEL_LSB] == CLKSEL_INTERNAL;
  assign sample_tick = use_internal ? int_tick : ext_sample_pulse;

  // ----------------------------------------------------------------
  // Decimation and rate accumulation
  // ----------------------------------------------------------------
  logic [DEC_BITS-1:0] dec_count;
  logic [DEC_BITS-1:0] next_dec_count;
  logic [DATA_W-1:0] rate_in [AXES];
  logic signed [ACC_W-1:0] acc [AXES];
  logic signed [ACC_W-1:0] next_acc [AXES];
  logic signed [ACC_W-1:0] total [AXES];
  logic [ACC_W-1:0] launch_mag [AXES];
  logic [ACC_W-1:0] next_launch_mag [AXES];
  logic [AXES-1:0] launch_neg;
  logic [AXES-1:0] next_launch_neg;
  logic [DIV_W-1:0] launch_div;
  logic [DIV_W-1:0] next_launch_div;
  logic launch;
  logic next_launch;
  logic cycle_end;

  assign rate_in[0] = gyro_y_rate;
  assign rate_in[1] = gyro_z_rate;
  // A setting lowered to or below dec_count ends the running cycle at the next tick
  assign cycle_end = sample_tick && (dec_count >= decimation_setting);

  always_comb begin
    next_dec_count = dec_count;
    next_launch = 1'b0;
    next_launch_div = launch_div;
    if (sample_tick) begin
      next_dec_count = cycle_end ? '0 : dec_count + DEC_BITS'(1);
    end
    if (cycle_end) begin
      next_launch = 1'b1;
      next_launch_div = {1'b0, decimation_setting} + DIV_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dec_count <= '0;
      launch <= 1'b0;
      launch_div <= DIV_W'(1);
    end else begin
      dec_count <= next_dec_count;
      launch <= next_launch;
      launch_div <= next_launch_div;
    end
  end

  // ----------------------------------------------------------------
  // Angle increment per axis
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] angle_increment [AXES];
  logic [DATA_W-1:0] next_angle [AXES];
  logic [AXES-1:0] div_done;

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      logic [ACC_W-1:0] quo;
      logic [ACC_W-1:0] signed_quo;

      // Sum of rate samples across one processing cycle
      always_comb begin
        total[g] = acc[g] + ACC_W'(signed'(rate_in[g]));
        next_acc[g] = acc[g];
        next_launch_mag[g] = launch_mag[g];
        next_launch_neg[g] = launch_neg[g];
        if (sample_tick) begin
          next_acc[g] = cycle_end ? '0 : total[g];
        end
        if (cycle_end) begin
          next_launch_neg[g] = total[g][ACC_W-1];
          next_launch_mag[g] = total[g][ACC_W-1] ?
            ACC_W'(-total[g]) : ACC_W'(total[g]);
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          acc[g] <= '0;
          launch_mag[g] <= '0;
          launch_neg[g] <= 1'b0;
        end else begin
          acc[g] <= next_acc[g];
          launch_mag[g] <= next_launch_mag[g];
          launch_neg[g] <= next_launch_neg[g];
        end
      end

      // Sum/(D+1) gives counts of scale*(D+1)/fs
      // A new cycle end restarts the divide; keep ticks 35 cycles apart
      iod_divider #(
        .N_W(ACC_W),
        .D_W(DIV_W)
      ) u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(launch),
        .dividend(launch_mag[g]),
        .divisor(launch_div),
        .busy(),
        .done(div_done[g]),
        .quotient(quo)
      );

      // Sign restored after the magnitude divide, so it rounds to zero
      assign signed_quo = launch_neg[g] ? ACC_W'(-quo) : quo;

      always_comb begin
        next_angle[g] = angle_increment[g];
        if (div_done[g]) begin
          next_angle[g] = signed_quo[DATA_W-1:0];
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          angle_increment[g] <= DATA_RESET;
        end else begin
          angle_increment[g] <= next_angle[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Acceleration registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] accel_primary [3];
  logic [DATA_W-1:0] accel_extension [3];
  logic [DATA_W-1:0] next_primary [3];
  logic [DATA_W-1:0] next_extension [3];
  logic [WIDE_W-1:0] accel_in [3];
  logic next_ready;

  assign accel_in[0] = accel_x_data;
  assign accel_in[1] = accel_y_data;
  assign accel_in[2] = accel_z_data;

  // All three pairs refresh together at the end of each cycle, so a
  // primary and extension read between refreshes stay coherent
  generate
    for (g = 0; g < 3; g++) begin : g_accel
      always_comb begin
        next_primary[g] = accel_primary[g];
        next_extension[g] = accel_extension[g];
        if (cycle_end) begin
          next_primary[g] = accel_in[g][WIDE_W-1:DATA_W];
          next_extension[g] = accel_in[g][DATA_W-1:0];
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          accel_primary[g] <= DATA_RESET;
          accel_extension[g] <= DATA_RESET;
        end else begin
          accel_primary[g] <= next_primary[g];
          accel_extension[g] <= next_extension[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Update flag
  // ----------------------------------------------------------------
  // Both dividers start on the same edge and finish together
  always_comb begin
    next_ready = &div_done;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_ready <= 1'b0;
    end else begin
      data_ready <= next_ready;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic wr_seen;

  // Writes reach no storage; every register here is read-only
  assign wr_seen = reg_wr & (|reg_wdata | 1'b1);

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] read_mux;
  logic next_rvalid;

  // Address decode of the read-only map
  always_comb begin
    case (reg_addr)
      OFS_ACCEL_X_EXTENSION: read_mux = accel_extension[0];
      OFS_ACCEL_X_PRIMARY: read_mux = accel_primary[0];
      OFS_ACCEL_Y_EXTENSION: read_mux = accel_extension[1];
      OFS_ACCEL_Y_PRIMARY: read_mux = accel_primary[1];
      OFS_ACCEL_Z_EXTENSION: read_mux = accel_extension[2];
      OFS_ACCEL_Z_PRIMARY: read_mux = accel_primary[2];
      OFS_ANGLE_INCREMENT_Y: read_mux = angle_increment[0];
      OFS_ANGLE_INCREMENT_Z: read_mux = angle_increment[1];
      default: read_mux = UNMAPPED_READ;
    endcase
  end

  // Read data loads only on a read and holds until the next one
  always_comb begin
    next_rdata = reg_rdata;
    next_rvalid = reg_rd;
    if (reg_rd && !wr_seen) begin
      next_rdata = read_mux;
    end else if (reg_rd) begin
      next_rdata = read_mux;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= DATA_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

endmodule : iod_output_regs

// >>> rtl/iod_pkg.sv
package iod_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int WIDE_W = 32;
  localparam int DEC_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_ACCEL_X_EXTENSION = 7'h10;
  localparam logic [ADDR_W-1:0] OFS_ACCEL_X_PRIMARY = 7'h12;
  localparam logic [ADDR_W-1:0] OFS_ACCEL_Y_EXTENSION = 7'h14;
  localparam logic [ADDR_W-1:0] OFS_ACCEL_Y_PRIMARY = 7'h16;
  localparam logic [ADDR_W-1:0] OFS_ACCEL_Z_EXTENSION = 7'h18;
  localparam logic [ADDR_W-1:0] OFS_ACCEL_Z_PRIMARY = 7'h1a;
  localparam logic [ADDR_W-1:0] OFS_ANGLE_INCREMENT_Y = 7'h26;
  localparam logic [ADDR_W-1:0] OFS_ANGLE_INCREMENT_Z = 7'h28;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CLKSEL_LSB = 2;
  localparam int CLKSEL_MSB = 3;
  localparam logic [1:0] CLKSEL_INTERNAL = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

  // ----------------------------------------------------------------
  // Scale factors and timing
  // ----------------------------------------------------------------
  localparam real GYRO_DPS_PER_COUNT = 0.005;
  localparam real ACCEL_MG_PER_COUNT = 0.25;
  localparam int CLK_HZ = 125_000_000;
  localparam int SAMPLE_HZ = 2048;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

endpackage : iod_pkg

// >>> rtl/iod_tick_gen.sv
`timescale 1ns/100ps
module iod_tick_gen
  import iod_pkg::*;
#(
  parameter int PERIOD = SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Tick
  output logic tick
);

  localparam logic [31:0] LAST = 32'(PERIOD - 1);

  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count + 32'h0000_0001;
    next_tick = 1'b0;
    if (count >= LAST) begin
      next_count = 32'h0000_0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

endmodule : iod_tick_gen

// >>> rtl/iod_divider.sv
`timescale 1ns/100ps
module iod_divider #(
  parameter int N_W = 32,
  parameter int D_W = 17
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire logic [N_W-1:0] dividend,
  input wire logic [D_W-1:0] divisor,
  // Result
  output logic busy,
  output logic done,
  output logic [N_W-1:0] quotient
);

  localparam int CNT_W = $clog2(N_W + 1);

  logic [D_W-1:0] rem;
  logic [D_W-1:0] next_rem;
  logic [N_W-1:0] next_quotient;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_busy;
  logic next_done;
  logic [D_W:0] shifted;
  logic [D_W:0] diff;

  // Restoring division, one quotient bit per clock
  always_comb begin
    next_rem = rem;
    next_quotient = quotient;
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    shifted = {rem, quotient[N_W-1]};
    diff = shifted - {1'b0, divisor};
    if (start) begin
      next_rem = '0;
      next_quotient = dividend;
      next_count = CNT_W'(N_W);
      next_busy = 1'b1;
    end else if (busy) begin
      if (shifted >= {1'b0, divisor}) begin
        next_rem = diff[D_W-1:0];
        next_quotient = {quotient[N_W-2:0], 1'b1};
      end else begin
        next_rem = shifted[D_W-1:0];
        next_quotient = {quotient[N_W-2:0], 1'b0};
      end
      next_count = count - CNT_W'(1);
      if (count == CNT_W'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rem <= '0;
      quotient <= '0;
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      rem <= next_rem;
      quotient <= next_quotient;
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : iod_divider

// >>> verification/iod_output_regs_properties.sv
`timescale 1ns/100ps
module iod_regs_chk
  import iod_pkg::*;
#(
  parameter int SAMPLE_PERIOD = 50
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire logic [DEC_W-1:0] decimation_setting,
  input wire logic [DATA_W-1:0] misc_control_word,
  input wire logic ext_sample_pulse,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  // Status
  input wire logic data_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Cycles since the last update, and how that update was paced
  logic [31:0] since_ready;
  logic last_internal;
  logic internal_fast;

  assign internal_fast = misc_control_word[3:2] == CLKSEL_INTERNAL &&
    decimation_setting == '0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      since_ready <= 32'h0000_0000;
      last_internal <= 1'b0;
    end else if (data_ready) begin
      since_ready <= 32'h0000_0001;
      last_internal <= internal_fast;
    end else begin
      since_ready <= since_ready + 32'h0000_0001;
    end
  end

  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !reg_rvalid && !data_ready && reg_rdata == DATA_RESET)
    else $error("outputs not cleared by reset");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered in one cycle");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read");
  a_data_holds: assert property ($changed(reg_rdata) |-> reg_rvalid)
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd &&
    !(reg_addr inside {[7'h10:7'h1a], 7'h26, 7'h28})
    |=> reg_rdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_ready_single: assert property (data_ready |=> !data_ready [*8])
    else $error("update flag longer than one cycle");
  a_ready_delay: assert property (ext_sample_pulse &&
    misc_control_word[3:2] != 2'h0 && decimation_setting == '0
    |=> !data_ready [*8] ##27 data_ready)
    else $error("external tick not followed by update");
  a_internal_rate: assert property (data_ready && internal_fast &&
    last_internal |-> since_ready == 32'(SAMPLE_PERIOD))
    else $error("internal update period wrong");

  c_read: cover property (reg_rvalid);
  c_write: cover property (reg_wr);
  c_internal: cover property (data_ready && misc_control_word[3:2] == 2'h0);
endmodule : iod_regs_chk

bind iod_output_regs iod_regs_chk #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (
  .mclk, .rst_n, .decimation_setting, .misc_control_word,
  .ext_sample_pulse, .reg_addr, .reg_rd, .reg_wr, .reg_rdata,
  .reg_rvalid, .data_ready);

// >>> verification/iod_host_model.sv
`timescale 1ns/100ps
module iod_host_model
  import iod_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 7'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  // Released lines show the inverse of the last value
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    d = reg_rvalid ? reg_rdata : 16'hxxxx;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd32(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    logic [DATA_W-1:0] lo;
    logic [DATA_W-1:0] hi;
    rd(a, lo);
    rd(a + 7'h02, hi);
    v = {hi, lo};
  endtask : rd32
endmodule : iod_host_model

// >>> verification/test_inertial_output_data_registers.sv
`timescale 1ns/100ps
module test_inertial_output_data_registers
  import iod_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [DEC_W-1:0] decimation_setting = 16'h0000;
  logic [DATA_W-1:0] misc_control_word = 16'h0004;
  logic ext_sample_pulse = 1'b0;
  logic [DATA_W-1:0] gyro_y_rate = 16'h0000;
  logic [DATA_W-1:0] gyro_z_rate = 16'h0000;
  logic [WIDE_W-1:0] accel_x_data = 32'h0000_0000;
  logic [WIDE_W-1:0] accel_y_data = 32'h0000_0000;
  logic [WIDE_W-1:0] accel_z_data = 32'h0000_0000;
  logic [ADDR_W-1:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic data_ready;
  logic [DATA_W-1:0] d;
  logic [WIDE_W-1:0] w;
  int errors = 0;
  int num_checks = 0;

  always #4 mclk = ~mclk;

  iod_output_regs #(.SAMPLE_PERIOD(50)) dut (.mclk, .rst_n,
    .decimation_setting, .misc_control_word, .ext_sample_pulse,
    .gyro_y_rate, .gyro_z_rate, .accel_x_data, .accel_y_data,
    .accel_z_data, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .data_ready);
  iod_host_model host (.mclk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_rvalid);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task wait_ready;
    int n;
    n = 0;
    while (data_ready !== 1'b1) begin
      @(negedge mclk);
      n++;
      if (n > 200) begin
        chk(32'h0000_0000, 32'h0000_0001);
        results;
      end
    end
  endtask : wait_ready

  task pulse;
    @(negedge mclk);
    ext_sample_pulse = 1'b1;
    @(negedge mclk);
    ext_sample_pulse = 1'b0;
  endtask : pulse

  task t_accel;
    accel_x_data = 32'h8000_0001;
    accel_y_data = 32'h7fff_ffff;
    accel_z_data = 32'h0001_fffe;
    gyro_y_rate = 16'h7fff;
    gyro_z_rate = 16'hffff;
    pulse;
    accel_x_data = 32'h0000_0000;
    wait_ready;
    host.rd32(OFS_ACCEL_X_EXTENSION, w);
    chk(w, 32'h8000_0001);
    host.rd32(OFS_ACCEL_Y_EXTENSION, w);
    chk(w, 32'h7fff_ffff);
    host.rd32(OFS_ACCEL_Z_EXTENSION, w);
    chk(w, 32'h0001_fffe);
    host.rd(OFS_ANGLE_INCREMENT_Y, d);
    chk(d, 16'h7fff);
    host.rd(OFS_ANGLE_INCREMENT_Z, d);
    chk(d, 16'hffff);
  endtask : t_accel

  task t_write;
    host.wr(OFS_ACCEL_X_PRIMARY, 16'h5a5a);
    host.wr(OFS_ANGLE_INCREMENT_Y, 16'h5a5a);
    host.rd(OFS_ACCEL_X_PRIMARY, d);
    chk(d, 16'h8000);
    host.rd(OFS_ANGLE_INCREMENT_Y, d);
    chk(d, 16'h7fff);
  endtask : t_write

  task t_decim;
    misc_control_word = 16'h000c;
    decimation_setting = 16'h0003;
    accel_y_data = 32'h1234_5678;
    for (int i = 0; i < 4; i++) begin
      gyro_y_rate = 16'(10 * i + 10 + i / 3);
      gyro_z_rate = -gyro_y_rate;
      repeat (40) @(negedge mclk);
      pulse;
    end
    wait_ready;
    host.rd(OFS_ANGLE_INCREMENT_Y, d);
    chk(d, 16'h0019);
    host.rd(OFS_ANGLE_INCREMENT_Z, d);
    chk(d, 16'hffe7);
    host.rd32(OFS_ACCEL_Y_EXTENSION, w);
    chk(w, 32'h1234_5678);
    host.rd32(OFS_ACCEL_X_EXTENSION, w);
    chk(w, 32'h0000_0000);
  endtask : t_decim

  task t_reset;
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    for (int a = 16; a < 44; a += 2) begin
      host.rd(7'(a), d);
      chk(d, 16'h0000);
    end
  endtask : t_reset

  task t_internal;
    decimation_setting = 16'h0000;
    misc_control_word = 16'h0000;
    gyro_y_rate = 16'h0005;
    gyro_z_rate = 16'hfffb;
    wait_ready;
    host.rd(OFS_ANGLE_INCREMENT_Y, d);
    chk(d, 16'h0005);
    host.rd(OFS_ANGLE_INCREMENT_Z, d);
    chk(d, 16'hfffb);
    wait_ready;
    host.rd(OFS_ANGLE_INCREMENT_Z, d);
    chk(d, 16'hfffb);
  endtask : t_internal

  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    t_accel;
    t_write;
    t_decim;
    t_reset;
    t_internal;
    results;
  end
endmodule : test_inertial_output_data_registers
